// *** src/insc_pkg.sv ***
// Constants, field layout and types for the interrupt nesting and standby controller
package insc_pkg;
  // Source and vector counts
  localparam int NSRC = 9;
  localparam int NVEC = 6;
  // Source bit positions in the request and enable words
  localparam int SRC_ITMR = 0; // Interval timer
  localparam int SRC_DUAL = 1; // Dual edge pin, shares vector 0
  localparam int SRC_SAMP = 2; // Sampled edge pin
  localparam int SRC_WATCH = 7; // Watch timer, wake only
  localparam int SRC_KEY = 8; // Key or rising pin, wake only
  // Register byte offsets
  localparam logic [7:0] OFS_PRIO = 8'h00;
  localparam logic [7:0] OFS_PSW = 8'h04;
  localparam logic [7:0] OFS_REQ = 8'h08;
  localparam logic [7:0] OFS_EN = 8'h0C;
  localparam logic [7:0] OFS_PCC = 8'h10;
  localparam logic [7:0] OFS_BTM = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Field positions
  localparam int PRIO_MIE = 3;
  localparam int PSW_NEST_HI = 3;
  localparam int PSW_NEST_LO = 2;
  localparam int PSW_MBE = 1;
  localparam int PSW_RBE = 0;
  localparam int PCC_STOP = 3;
  localparam int PCC_HALT = 2;
  localparam int VEC_MBE = 15;
  localparam int VEC_RBE = 14;
  localparam int ISR_AW = 14;
  // Reset values
  localparam logic [3:0] PRIO_RST = 4'h0;
  localparam logic [3:0] PSW_RST = 4'h0;
  localparam logic [3:0] PCC_RST = 4'h0;
  localparam logic [3:0] BTM_RST = 4'h0;
  localparam logic [NSRC-1:0] FLAG_RST = 9'h000;
  // Nesting status codes
  localparam logic [1:0] NEST_NORMAL = 2'h0;
  localparam logic [1:0] NEST_ANY = 2'h1;
  localparam logic [1:0] NEST_HIGH = 2'h2;
  // Wait selections of the interval timer mode
  localparam logic [2:0] BTM_W20 = 3'h0;
  localparam logic [2:0] BTM_W17 = 3'h3;
  localparam logic [2:0] BTM_W15 = 3'h5;
  localparam logic [2:0] BTM_W13 = 3'h7;
  // Wait lengths in main clock cycles
  localparam int WAIT_W20 = 1048576;
  localparam int WAIT_W17 = 131072;
  localparam int WAIT_W15 = 32768;
  localparam int WAIT_W13 = 8192;
  localparam int WAIT_CW = 21;
  // Instructions run after a wake before vectoring
  localparam logic [1:0] DEFER_INSTR = 2'h2;
  // Standby state
  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STOP, ST_STOP_WAIT} insc_sby_t;
endpackage : insc_pkg

// *** src/insc_wait_if.sv ***
// Handshake between standby control and the release wait timer
interface insc_wait_if;
  logic start; // One-cycle request to begin a wait
  logic [2:0] sel; // Wait length selection
  logic busy; // Wait in progress
  logic done; // One-cycle pulse at wait end
  modport ctrl (output start, output sel, input busy, input done);
  modport timer (input start, input sel, output busy, output done);
endinterface : insc_wait_if

// *** src/insc_wait_timer.sv ***
// Release wait timer used when stop mode ends on an interrupt
module insc_wait_timer #(
  parameter int W20 = 1048576,
  parameter int W17 = 131072,
  parameter int W15 = 32768,
  parameter int W13 = 8192
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Control side
  insc_wait_if.timer wt
);
  import insc_pkg::*;

  logic [WAIT_CW-1:0] cnt; // Cycles left
  logic [WAIT_CW-1:0] len; // Selected length

  // Length lookup; prohibited codes fall back to the longest wait
  always_comb begin
    case (wt.sel)
      BTM_W17: len = WAIT_CW'(W17);
      BTM_W15: len = WAIT_CW'(W15);
      BTM_W13: len = WAIT_CW'(W13);
      default: len = WAIT_CW'(W20);
    endcase
  end

  // Down counter, done pulses once at zero
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt <= '0;
      wt.busy <= 1'b0;
      wt.done <= 1'b0;
    end else begin
      wt.done <= 1'b0;
      if (wt.start && !wt.busy) begin
        cnt <= len - WAIT_CW'(1);
        wt.busy <= 1'b1;
      end else if (wt.busy) begin
        if (cnt == '0) begin
          wt.busy <= 1'b0;
          wt.done <= 1'b1;
        end else begin
          cnt <= cnt - WAIT_CW'(1);
        end
      end
    end
  end
endmodule : insc_wait_timer

// *** src/insc_top.sv ***
// Interrupt acceptance, nesting status and standby control with a Wishbone register file
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
module insc_top #(
  parameter int WAIT_W20_P = insc_pkg::WAIT_W20,
  parameter int WAIT_W17_P = insc_pkg::WAIT_W17,
  parameter int WAIT_W15_P = insc_pkg::WAIT_W15,
  parameter int WAIT_W13_P = insc_pkg::WAIT_W13
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Source events, one-cycle pulses
  input wire logic [insc_pkg::NSRC-1:0] src_event_i,
  // Instruction sequencer
  input wire logic stop_instr_i,
  input wire logic halt_instr_i,
  input wire logic instr_done_i,
  input wire logic irq_ack_i,
  input wire logic return_from_irq_instr_i,
  input wire logic [3:0] return_from_irq_instr_psw_i,
  input wire logic [15:0] vec_entry_i,
  output logic irq_req_o,
  output logic [2:0] vec_num_o,
  output logic [insc_pkg::ISR_AW-1:0] isr_addr_o,
  output logic [3:0] psw_saved_o,
  output logic [3:0] psw_o,
  output logic vectored_request_o,
  // Clock generator status
  input wire logic cpu_on_subclk_i,
  input wire logic main_osc_off_i,
  // Peripheral clock choices
  input wire logic ser_a_ext_clk_i,
  input wire logic ser_b_ext_clk_i,
  input wire logic counter_pin_clk_i,
  input wire logic watch_on_subclk_i,
  // Clock and peripheral run controls
  output logic cpu_clk_gate_o,
  output logic main_osc_stop_o,
  output logic osc_in_tie_low_o,
  output logic interval_timer_run_o,
  output logic ser_a_run_o,
  output logic ser_b_run_o,
  output logic counter_run_o,
  output logic watch_run_o,
  output logic conv_run_o,
  output logic pulse_run_o
);
  import insc_pkg::*;

  logic [3:0] priority_select_reg; // Select and master enable
  logic [3:0] program_status_word; // Nest status and bank flags
  logic [3:0] proc_clock_ctrl; // Clock select, halt, stop
  logic [3:0] interval_timer_mode; // Wait selection
  logic [NSRC-1:0] req_flag; // Request flags
  logic [NSRC-1:0] en_flag; // Enable flags
  logic [NSRC-1:0] next_req; // Request flags after a software write, before acceptance clear and events
  logic [NSRC-1:0] acc_clr; // Flags cleared by acceptance
  logic [NSRC-1:0] ev; // Events after standby gating
  logic [NSRC-1:0] pend; // Request and enable both set
  logic [NVEC-1:0] vreq; // Pending per vector
  insc_sby_t state; // Standby state
  logic [1:0] defer_cnt; // Instructions left before vectoring
  logic [1:0] nest; // Current nesting status
  logic [2:0] sel; // Chosen high source vector
  logic [2:0] lo_vec; // Lowest pending vector
  logic hi_ok; // Chosen high source pending
  logic master_irq_enable; // Bit 3 of the select register
  logic wake; // Any enabled request
  logic acc; // Acceptance this cycle
  logic wr; // Bus write strobe
  logic [31:0] rd_data; // Read mux
  logic go_stop; // Stop entered this cycle
  logic go_halt; // Halt requested this cycle; entered only when wake is low
  logic leave; // Standby left this cycle
  logic main_runs; // Main clock running
  insc_wait_if wt ();

  // Release wait timer
  insc_wait_timer #(.W20(WAIT_W20_P), .W17(WAIT_W17_P), .W15(WAIT_W15_P), .W13(WAIT_W13_P)) u_wait (
    .mclk_i(mclk_i), .reset_i(reset_i), .wt(wt));

  // Bus handshake: ack one cycle after the request, write lands on the ack edge
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // Read mux; unmapped offsets read zero and ignore writes
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      OFS_PRIO: rd_data[3:0] = priority_select_reg;
      OFS_PSW: rd_data[3:0] = program_status_word;
      OFS_REQ: rd_data[NSRC-1:0] = req_flag;
      OFS_EN: rd_data[NSRC-1:0] = en_flag;
      OFS_PCC: rd_data[3:0] = proc_clock_ctrl;
      OFS_BTM: rd_data[3:0] = interval_timer_mode;
      OFS_STAT: rd_data[5:0] = {defer_cnt, wake, wt.busy, 2'(state)};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Event gating in standby
  assign ev = src_event_i & ~(NSRC'(state != ST_RUN) << SRC_SAMP)
    & ~(NSRC'(state == ST_STOP) << SRC_ITMR);

  // Request and vector decode
  assign pend = req_flag & en_flag;
  assign wake = |pend;
  assign vreq = {pend[6:2], pend[SRC_ITMR] | pend[SRC_DUAL]};
  assign nest = program_status_word[PSW_NEST_HI:PSW_NEST_LO];
  assign master_irq_enable = priority_select_reg[PRIO_MIE];
  assign sel = priority_select_reg[2:0];
  assign hi_ok = (sel < 3'(NVEC)) && vreq[sel];

  // Fixed order among vectors, lowest index first
  always_comb begin
    lo_vec = 3'h0;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (vreq[i]) lo_vec = 3'(i);
    end
  end

  // Offer an interrupt; status 10 and 11 block all
  always_comb begin
    irq_req_o = 1'b0;
    vec_num_o = lo_vec;
    if (master_irq_enable && state == ST_RUN && defer_cnt == 2'h0) begin
      if (hi_ok && (nest == NEST_NORMAL || nest == NEST_ANY)) begin
        irq_req_o = 1'b1;
        vec_num_o = sel;
      end else if (nest == NEST_NORMAL && |vreq) begin
        irq_req_o = 1'b1;
      end
    end
  end
  assign acc = irq_ack_i && irq_req_o;

  // Flags cleared on acceptance; shared vector depends on which are enabled
  always_comb begin
    acc_clr = '0;
    if (acc) begin
      if (vec_num_o == 3'h0) begin
        if (en_flag[SRC_ITMR] && !en_flag[SRC_DUAL]) begin
          acc_clr[SRC_ITMR] = 1'b1;
        end else if (en_flag[SRC_DUAL] && !en_flag[SRC_ITMR]) begin
          acc_clr[SRC_DUAL] = 1'b1;
        end
      end else begin
        acc_clr[vec_num_o + 3'h1] = 1'b1;
      end
    end
  end

  // Request flags: software write, then clear, then hardware set wins
  always_comb begin
    next_req = req_flag;
    if (wr && wb_adr_i == OFS_REQ) begin
      if (wb_sel_i[0]) next_req[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) next_req[8] = wb_dat_i[8];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      req_flag <= FLAG_RST;
    end else begin
      req_flag <= (next_req & ~acc_clr) | ev;
    end
  end

  // Enable flags and select register, written by software only
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      en_flag <= FLAG_RST;
      priority_select_reg <= PRIO_RST;
      interval_timer_mode <= BTM_RST;
    end else if (wr) begin
      if (wb_adr_i == OFS_EN && wb_sel_i[0]) en_flag[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == OFS_EN && wb_sel_i[1]) en_flag[8] <= wb_dat_i[8];
      if (wb_adr_i == OFS_PRIO && wb_sel_i[0]) priority_select_reg <= wb_dat_i[3:0];
      if (wb_adr_i == OFS_BTM && wb_sel_i[0]) interval_timer_mode <= wb_dat_i[3:0];
    end
  end

  // Status word: acceptance raises status and loads banks, return restores
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      program_status_word <= PSW_RST;
      psw_saved_o <= PSW_RST;
      isr_addr_o <= '0;
    end else if (acc) begin
      psw_saved_o <= program_status_word;
      program_status_word[PSW_NEST_HI:PSW_NEST_LO] <= nest + 2'h1;
      program_status_word[PSW_MBE] <= vec_entry_i[VEC_MBE];
      program_status_word[PSW_RBE] <= vec_entry_i[VEC_RBE];
      isr_addr_o <= vec_entry_i[ISR_AW-1:0];
    end else if (return_from_irq_instr_i) begin
      program_status_word <= return_from_irq_instr_psw_i;
    end else if (wr && wb_adr_i == OFS_PSW && wb_sel_i[0]) begin
      program_status_word <= wb_dat_i[3:0];
    end
  end
  assign psw_o = program_status_word;

  // Standby entry and exit conditions
  assign go_stop = state == ST_RUN && stop_instr_i && !cpu_on_subclk_i;
  assign go_halt = state == ST_RUN && halt_instr_i && !stop_instr_i;
  assign leave = (state == ST_HALT && wake) || (state == ST_STOP_WAIT && wt.done);
  // A pending request at stop entry goes straight to the wait
  assign wt.start = (go_stop && wake) || (state == ST_STOP && wake);
  assign wt.sel = interval_timer_mode[2:0];

  // Standby state; reset alone also ends standby
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: begin
          if (go_stop) begin
            state <= wake ? ST_STOP_WAIT : ST_STOP;
          end else if (go_halt && !wake) begin
            state <= ST_HALT;
          end
        end
        ST_HALT: if (wake) state <= ST_RUN;
        ST_STOP: if (wake) state <= ST_STOP_WAIT;
        ST_STOP_WAIT: if (wt.done) state <= ST_RUN;
        default: state <= ST_RUN;
      endcase
    end
  end

  // Clock control: instructions set the mode bits, leaving standby clears them
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      proc_clock_ctrl <= PCC_RST;
    end else begin
      if (wr && wb_adr_i == OFS_PCC && wb_sel_i[0]) begin
        proc_clock_ctrl[1:0] <= wb_dat_i[1:0];
      end
      if (go_stop) begin
        proc_clock_ctrl[PCC_STOP] <= 1'b1;
      end else if (go_halt && !wake) begin
        proc_clock_ctrl[PCC_HALT] <= 1'b1;
      end else if (leave) begin
        proc_clock_ctrl[PCC_STOP] <= 1'b0;
        proc_clock_ctrl[PCC_HALT] <= 1'b0;
      end
    end
  end

  // Defer vectoring for two instructions after an interrupt wake
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      defer_cnt <= 2'h0;
    end else if (leave && master_irq_enable) begin
      defer_cnt <= DEFER_INSTR;
    end else if (instr_done_i && defer_cnt != 2'h0) begin
      defer_cnt <= defer_cnt - 2'h1;
    end
  end

  // Clock and peripheral run controls, registered to avoid glitches on gates
  assign main_runs = state != ST_STOP && !main_osc_off_i;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cpu_clk_gate_o <= 1'b0;
      main_osc_stop_o <= 1'b0;
      osc_in_tie_low_o <= 1'b0;
      interval_timer_run_o <= 1'b1;
      ser_a_run_o <= 1'b1;
      ser_b_run_o <= 1'b1;
      counter_run_o <= 1'b1;
      watch_run_o <= 1'b1;
      conv_run_o <= 1'b1;
      pulse_run_o <= 1'b1;
      vectored_request_o <= 1'b0;
    end else begin
      cpu_clk_gate_o <= state != ST_RUN;
      main_osc_stop_o <= state == ST_STOP;
      osc_in_tie_low_o <= state == ST_STOP;
      interval_timer_run_o <= state != ST_STOP;
      ser_a_run_o <= main_runs || ser_a_ext_clk_i;
      ser_b_run_o <= main_runs || (state == ST_STOP && ser_b_ext_clk_i);
      counter_run_o <= main_runs || (state == ST_STOP && counter_pin_clk_i);
      watch_run_o <= state != ST_STOP || watch_on_subclk_i;
      conv_run_o <= main_runs;
      pulse_run_o <= main_runs;
      vectored_request_o <= wake;
    end
  end

  // Checks
  a_ack_single: assert property (@(posedge mclk_i) disable iff (reset_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_status_step: assert property (@(posedge mclk_i) disable iff (reset_i)
    acc && !return_from_irq_instr_i |=> nest == $past(nest) + 2'h1) else $error("status not raised");
  a_high_blocks: assert property (@(posedge mclk_i) disable iff (reset_i)
    nest[1] |-> !irq_req_o) else $error("offer in status 10 or 11");
  a_low_gated: assert property (@(posedge mclk_i) disable iff (reset_i)
    irq_req_o && nest == NEST_ANY |-> vec_num_o == sel) else $error("low offer in status 1");
  a_psw_saved: assert property (@(posedge mclk_i) disable iff (reset_i)
    acc |=> psw_saved_o == $past(program_status_word)) else $error("word not saved");
  a_stop_bit: assert property (@(posedge mclk_i) disable iff (reset_i)
    go_stop |=> proc_clock_ctrl[PCC_STOP] && state != ST_RUN) else $error("stop not set");
  a_stop_subclk: assert property (@(posedge mclk_i) disable iff (reset_i)
    state == ST_RUN && cpu_on_subclk_i |=> state != ST_STOP) else $error("stop on subclock");
  a_halt_wake: assert property (@(posedge mclk_i) disable iff (reset_i)
    state == ST_HALT && wake |=> state == ST_RUN ##1 !cpu_clk_gate_o) else $error("no wake");
  a_timer_held: assert property (@(posedge mclk_i) disable iff (reset_i)
    state == ST_STOP ##1 state == ST_STOP |-> !interval_timer_run_o) else $error("timer runs");
  a_shared_keep: assert property (@(posedge mclk_i) disable iff (reset_i)
    acc && vec_num_o == 3'h0 && en_flag[SRC_ITMR] && en_flag[SRC_DUAL] && !wr
    |=> (req_flag[1:0] & $past(req_flag[1:0])) == $past(req_flag[1:0]))
    else $error("shared flag cleared");
  a_defer_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    defer_cnt != 2'h0 |-> !irq_req_o) else $error("vectored during defer");
  c_nested: cover property (@(posedge mclk_i) disable iff (reset_i) acc && nest == NEST_ANY);
  c_shared: cover property (@(posedge mclk_i) disable iff (reset_i) acc && vec_num_o == 3'h0);
  c_halt_wake: cover property (@(posedge mclk_i) disable iff (reset_i) state == ST_HALT && wake);
  c_stop_done: cover property (@(posedge mclk_i) disable iff (reset_i) wt.done);
endmodule : insc_top

// *** verification/insc_seq_model.sv ***
// Behavioural instruction sequencer facing the interrupt controller
module insc_seq_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Bench controls
  input wire logic take_i,
  input wire logic pop_i,
  // Controller side
  input wire logic irq_req_o,
  input wire logic [2:0] vec_num_o,
  input wire logic [3:0] psw_saved_o,
  output logic irq_ack_i,
  output logic return_from_irq_instr_i,
  output logic [3:0] return_from_irq_instr_psw_i,
  output logic instr_done_i,
  output logic [15:0] vec_entry_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] stack[$]; // Pushed status words
  logic [1:0] dly; // Random answer delay, prompt or slow
  logic ack_d; // Push pending one cycle after ack
  int seed = 27;
  // Vector ROM: bank flags from vector bits, routine at 0x100 plus the vector number
  assign vec_entry_i = {vec_num_o[0], vec_num_o[1], 14'h0100 + 14'(vec_num_o)};
  // Ack, push on acceptance, pop on return
  always @(posedge mclk_i) begin
    if (reset_i) begin
      {irq_ack_i, return_from_irq_instr_i, ack_d, instr_done_i, dly} <= 6'h00;
      return_from_irq_instr_psw_i <= 4'h0;
    end else begin
      irq_ack_i <= 1'h0;
      return_from_irq_instr_i <= pop_i;
      ack_d <= irq_ack_i;
      // Instructions keep completing, one every two cycles
      instr_done_i <= ~instr_done_i;
      if (ack_d) stack.push_back(psw_saved_o);
      if (pop_i) return_from_irq_instr_psw_i <= stack.pop_back();
      if (irq_req_o && take_i && !irq_ack_i && !ack_d) begin
        if (dly == 2'h0) begin
          irq_ack_i <= 1'h1;
          dly <= 2'($random(seed));
        end else dly <= dly - 2'h1;
      end
    end
  end
endmodule : insc_seq_model

// *** verification/tb_top.sv ***
// Self-checking bench for the interrupt nesting and standby controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import insc_pkg::*;
  logic mclk_i = 0, reset_i = 1, take = 0, pop = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [NSRC-1:0] src_event_i = 9'h000;
  logic stop_instr_i = 0, halt_instr_i = 0, cpu_on_subclk_i = 0, main_osc_off_i = 0;
  logic ser_a_ext_clk_i = 0, ser_b_ext_clk_i = 0, counter_pin_clk_i = 0, watch_on_subclk_i = 0;
  logic wb_ack_o, irq_req_o, vectored_request_o, irq_ack_i, return_from_irq_instr_i, instr_done_i;
  logic [2:0] vec_num_o;
  logic [ISR_AW-1:0] isr_addr_o;
  logic [3:0] psw_saved_o, psw_o, return_from_irq_instr_psw_i;
  logic [15:0] vec_entry_i;
  logic cpu_clk_gate_o, main_osc_stop_o, osc_in_tie_low_o, interval_timer_run_o;
  logic ser_a_run_o, ser_b_run_o, counter_run_o, watch_run_o, conv_run_o, pulse_run_o;
  int num_errors = 0, check_count = 0, cycles = 0, seed = 27;
  logic [31:0] r;
  // Short waits stand in for the long release counts
  insc_top #(.WAIT_W20_P(16), .WAIT_W17_P(12), .WAIT_W15_P(8), .WAIT_W13_P(4)) insc_top_inst (
    .mclk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .src_event_i, .stop_instr_i, .halt_instr_i, .instr_done_i,
    .irq_ack_i, .return_from_irq_instr_i, .return_from_irq_instr_psw_i, .vec_entry_i, .irq_req_o, .vec_num_o, .isr_addr_o,
    .psw_saved_o, .psw_o, .vectored_request_o, .cpu_on_subclk_i, .main_osc_off_i,
    .ser_a_ext_clk_i, .ser_b_ext_clk_i, .counter_pin_clk_i, .watch_on_subclk_i,
    .cpu_clk_gate_o, .main_osc_stop_o, .osc_in_tie_low_o, .interval_timer_run_o,
    .ser_a_run_o, .ser_b_run_o, .counter_run_o, .watch_run_o, .conv_run_o, .pulse_run_o);
  insc_seq_model insc_seq_model_inst (.mclk_i, .reset_i, .take_i(take), .pop_i(pop),
    .irq_req_o, .vec_num_o, .psw_saved_o, .irq_ack_i, .return_from_irq_instr_i, .return_from_irq_instr_psw_i,
    .instr_done_i, .vec_entry_i);
  // 100 ns clock
  initial forever #50 mclk_i = ~mclk_i;
  // Hang guard, far above the expected run length
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (e !== g) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Wait for ack however long it takes; only the hang guard ends this
    do @(posedge mclk_i); while (wb_ack_o !== 1'h1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(nm, e, r);
  endtask : rdc
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  task automatic ev(int s);
    @(posedge mclk_i) src_event_i <= 9'h001 << s;
    @(posedge mclk_i) src_event_i <= 9'h000;
  endtask : ev
  task automatic wn(logic [1:0] n);
    for (int i = 0; i < 50; i++) begin
      @(posedge mclk_i);
      if (psw_o[3:2] === n) break;
    end
    cyc(1);
  endtask : wn
  task automatic rt();
    @(posedge mclk_i) pop <= 1'h1;
    @(posedge mclk_i) pop <= 1'h0;
    cyc(3);
  endtask : rt
  task automatic sby(logic s);
    @(posedge mclk_i) {stop_instr_i, halt_instr_i} <= {s, ~s};
    // Nothing issued in the next slot: stands for the no-op after standby
    @(posedge mclk_i) {stop_instr_i, halt_instr_i} <= 2'h0;
    cyc(3);
  endtask : sby
  // Pushed word fields: status, then bank flags of the vector
  function automatic logic [3:0] xp(logic [1:0] n, logic [2:0] v);
    return {n, v[0], v[1]};
  endfunction : xp
  initial begin
    cyc(3);
    reset_i <= 1'h0;
    rdc("prio", OFS_PRIO, 32'h0);
    rdc("psw", OFS_PSW, 32'h0);
    rdc("unmapped", 8'h1C, 32'h0);
    $display("test reset done");
    // Source 3 on vector 2 is low, source 5 on vector 4 is selected high
    wb(1'h1, OFS_EN, 32'h28);
    wb(1'h1, OFS_PRIO, 32'hC);
    take <= 1'h1;
    ev(3);
    wn(2'h1);
    chk("psw low", xp(2'h1, 3'h2), psw_o);
    chk("isr", 32'h102, isr_addr_o);
    ev(3);
    cyc(20);
    chk("low blocked", 32'h1, psw_o[3:2]);
    ev(5);
    wn(2'h2);
    chk("psw high", xp(2'h2, 3'h4), psw_o);
    ev(5);
    cyc(20);
    take <= 1'h0;
    chk("status 2 blocks", 32'h2, psw_o[3:2]);
    rt();
    chk("restore", xp(2'h1, 3'h2), psw_o);
    chk("high only", 32'h4, vec_num_o);
    rt();
    chk("restore 0", 32'h0, psw_o);
    chk("high wins", 32'h4, vec_num_o);
    // Status flags are rewritten only with the master enable off
    wb(1'h1, OFS_PRIO, 32'h4);
    wb(1'h1, OFS_PSW, 32'hC);
    wb(1'h1, OFS_PRIO, 32'hC);
    cyc(2);
    chk("status 3 blocks", 32'h0, irq_req_o);
    wb(1'h1, OFS_PRIO, 32'h4);
    wb(1'h1, OFS_PSW, 32'h0);
    wb(1'h1, OFS_REQ, 32'h0);
    wb(1'h1, OFS_PRIO, 32'hC);
    $display("test nesting done");
    // Shared vector 0: one enabled, then both
    wb(1'h1, OFS_EN, 32'h2);
    take <= 1'h1;
    ev(1);
    wn(2'h1);
    rdc("single cleared", OFS_REQ, 32'h0);
    take <= 1'h0;
    rt();
    wb(1'h1, OFS_EN, 32'h3);
    ev(0);
    ev(1);
    take <= 1'h1;
    wn(2'h1);
    take <= 1'h0;
    rdc("both kept", OFS_REQ, 32'h3);
    rt();
    wb(1'h1, OFS_REQ, 32'h0);
    wb(1'h1, OFS_EN, 32'h8);
    $display("test shared done");
    // Halt, random main oscillator and clock choices
    // Clock select rewritten, then the switch delay before standby
    wb(1'h1, OFS_PCC, 32'h0);
    cyc(4);
    sby(1'h0);
    chk("halt gate", 32'h1, cpu_clk_gate_o);
    chk("halt osc", 32'h0, main_osc_stop_o);
    rdc("halt bit", OFS_PCC, 32'h4);
    repeat (4) begin
      r = $random(seed);
      {main_osc_off_i, ser_a_ext_clk_i} <= r[1:0];
      cyc(3);
      chk("ser a halt", 32'(!r[1] || r[0]), ser_a_run_o);
      chk("ser b halt", 32'(!r[1]), ser_b_run_o);
      chk("others halt", {3{!r[1]}}, {counter_run_o, conv_run_o, pulse_run_o});
      chk("watch halt", 32'h1, watch_run_o);
      chk("timer halt", 32'h1, interval_timer_run_o);
    end
    main_osc_off_i <= 1'h0;
    ev(3);
    cyc(3);
    chk("vrq", 32'h1, vectored_request_o);
    chk("halt wake", 32'h0, cpu_clk_gate_o);
    wb(1'h1, OFS_REQ, 32'h0);
    $display("test halt done");
    // Stop: refused on the subsystem clock, then entered
    cpu_on_subclk_i <= 1'h1;
    sby(1'h1);
    chk("stop refused", 32'h0, cpu_clk_gate_o);
    cpu_on_subclk_i <= 1'h0;
    sby(1'h1);
    chk("tie low", 32'h1, osc_in_tie_low_o);
    chk("osc stop", 32'h1, main_osc_stop_o);
    chk("timer stop", 32'h0, interval_timer_run_o);
    chk("conv stop", 32'h0, conv_run_o | pulse_run_o);
    rdc("stop bit", OFS_PCC, 32'h8);
    repeat (4) begin
      r = $random(seed);
      {ser_a_ext_clk_i, ser_b_ext_clk_i, counter_pin_clk_i, watch_on_subclk_i} <= r[3:0];
      cyc(3);
      chk("stop runs", r[3:0], {ser_a_run_o, ser_b_run_o, counter_run_o, watch_run_o});
    end
    ev(3);
    cyc(40);
    chk("stop wake", 32'h0, main_osc_stop_o);
    sby(1'h0);
    chk("pending halt", 32'h0, cpu_clk_gate_o);
    // Pending request at stop entry: oscillator kept, shortest wait, then run
    wb(1'h1, OFS_BTM, 32'h7);
    sby(1'h1);
    chk("pending stop gate", 32'h1, cpu_clk_gate_o);
    chk("pending stop osc", 32'h0, main_osc_stop_o);
    cyc(6);
    chk("short wait", 32'h0, cpu_clk_gate_o);
    $display("test stop done");
    // Reset alone ends stop and clears the registers
    wb(1'h1, OFS_REQ, 32'h0);
    sby(1'h1);
    chk("stop again", 32'h1, main_osc_stop_o);
    reset_i <= 1'h1;
    cyc(3);
    reset_i <= 1'h0;
    cyc(2);
    chk("reset release", 32'h0, main_osc_stop_o | cpu_clk_gate_o);
    rdc("reset prio", OFS_PRIO, 32'h0);
    $display("test reset in stop done");
    conclude();
  end
endmodule : tb_top
